//--- rtl/cocr_i2c_slave.v
// I2C byte slave with register pointer and auto increment
`timescale 1ns/100ps
`include "cocr_map.vh"

module cocr_i2c_slave
(
  // Clock and reset
  input  wire       clock,
  input  wire       reset_n,
  // I2C pins
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe_n,
  // Register access
  output reg        wr_en,
  output reg  [7:0] wr_addr,
  output reg  [7:0] wr_data,
  output wire [7:0] rd_addr,
  input  wire [7:0] rd_data
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_WACK = 3'h2;
  localparam [2:0] ST_WR   = 3'h3;
  localparam [2:0] ST_RD   = 3'h4;
  localparam [2:0] ST_MACK = 3'h5;

  reg [1:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  reg       scl_d_reg;
  reg       sda_d_reg;
  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] ptr_reg;
  reg       read_reg;
  reg       got_ptr_reg;
  reg       nack_reg;

  wire scl = scl_sync_reg[1];
  wire sda = sda_sync_reg[1];
  wire scl_rise = scl & ~scl_d_reg;
  wire scl_fall = ~scl & scl_d_reg;
  wire start_seen = scl & scl_d_reg & ~sda & sda_d_reg;
  wire stop_seen  = scl & scl_d_reg & sda & ~sda_d_reg;

  assign rd_addr = ptr_reg;

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      ptr_reg      <= 8'h00;
      read_reg     <= 1'b0;
      got_ptr_reg  <= 1'b0;
      nack_reg     <= 1'b0;
      sda_out      <= 1'b0;
      sda_oe_n     <= 1'b1;
      wr_en        <= 1'b0;
      wr_addr      <= 8'h00;
      wr_data      <= 8'h00;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg    <= scl;
      sda_d_reg    <= sda;
      wr_en        <= 1'b0;
      if (start_seen)
      begin
        state_reg   <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_n    <= 1'b1;
      end
      else if (stop_seen)
      begin
        state_reg <= ST_IDLE;
        sda_oe_n  <= 1'b1;
      end
      else
      begin
        case (state_reg)
          ST_ADDR, ST_WR:
          begin
            if (scl_rise)
            begin
              shift_reg   <= {shift_reg[6:0], sda};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            else if (scl_fall && bit_cnt_reg == 4'h8)
            begin
              bit_cnt_reg <= 4'h0;
              state_reg   <= ST_WACK;
              sda_oe_n    <= 1'b0;
              if (state_reg == ST_ADDR)
              begin
                read_reg    <= shift_reg[0];
                got_ptr_reg <= shift_reg[0];
                if (shift_reg[7:1] != `COCR_I2C_DEV_ADDR)
                begin
                  state_reg <= ST_IDLE;
                  sda_oe_n  <= 1'b1;
                end
              end
              else if (!got_ptr_reg)
              begin
                ptr_reg     <= shift_reg;
                got_ptr_reg <= 1'b1;
              end
              else
              begin
                // Low byte and high byte are separate addresses
                wr_en   <= 1'b1;
                wr_addr <= ptr_reg;
                wr_data <= shift_reg;
                ptr_reg <= ptr_reg + 8'h01;
              end
            end
          end
          ST_WACK:
          begin
            if (scl_fall)
            begin
              if (read_reg)
              begin
                state_reg <= ST_RD;
                sda_oe_n  <= rd_data[7];
                shift_reg <= {rd_data[6:0], 1'b0};
                ptr_reg   <= ptr_reg + 8'h01;
              end
              else
              begin
                state_reg <= ST_WR;
                sda_oe_n  <= 1'b1;
              end
            end
          end
          ST_RD:
          begin
            if (scl_rise)
            begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            else if (scl_fall)
            begin
              if (bit_cnt_reg == 4'h8)
              begin
                bit_cnt_reg <= 4'h0;
                state_reg   <= ST_MACK;
                sda_oe_n    <= 1'b1;
              end
              else
              begin
                sda_oe_n  <= shift_reg[7];
                shift_reg <= {shift_reg[6:0], 1'b0};
              end
            end
          end
          ST_MACK:
          begin
            if (scl_rise)
            begin
              nack_reg <= sda;
            end
            else if (scl_fall)
            begin
              if (nack_reg)
              begin
                state_reg <= ST_IDLE;
              end
              else
              begin
                state_reg <= ST_RD;
                sda_oe_n  <= rd_data[7];
                shift_reg <= {rd_data[6:0], 1'b0};
                ptr_reg   <= ptr_reg + 8'h01;
              end
            end
          end
          default:
          begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

//--- rtl/cocr_map.vh
// Register map, field positions, reset values and timing counts of the option block
`ifndef COCR_MAP_VH
`define COCR_MAP_VH

// I2C slave address; arbitrary value
`define COCR_I2C_DEV_ADDR      7'h09

// Register byte addresses
`define COCR_OPT_LO_ADDR       8'h30
`define COCR_OPT_HI_ADDR       8'h31
`define COCR_LIM_LO_ADDR       8'h0E
`define COCR_LIM_HI_ADDR       8'h0F

// Reset values
`define COCR_OPT_RESET         16'h3300
`define COCR_LIM_RESET         7'h20

// Upper byte fields
`define COCR_HI_BATT_MON       7
`define COCR_HI_LP_HOT         6
`define COCR_HI_SYSTEM_POWER_OUTPUT_MSB       5
`define COCR_HI_SYSTEM_POWER_OUTPUT_LSB       4
`define COCR_HI_IN_RES         3
`define COCR_HI_CHG_RES        2
`define COCR_HI_GAIN           1
`define COCR_HI_FAST           0

// Lower byte fields
`define COCR_LO_PTM            2
`define COCR_LO_SHIP           1

// System power sense modes
`define COCR_SYSTEM_POWER_OUTPUT_SUM          2'h0
`define COCR_SYSTEM_POWER_OUTPUT_INPUT        2'h1
`define COCR_SYSTEM_POWER_OUTPUT_RSVD         2'h2
`define COCR_SYSTEM_POWER_OUTPUT_OFF          2'h3

// Input current limit codes, 100 mA per step
`define COCR_LIM_MAX_SLOW      7'h64
`define COCR_LIM_MAX_FAST      7'h40

// Ship discharge time
`define COCR_CLK_MHZ           100
`define COCR_SHIP_MS           140
`define COCR_SHIP_CYCLES       (`COCR_SHIP_MS * 1000 * `COCR_CLK_MHZ)

`endif

//--- rtl/cocr_option_reg.v
// Charger option register pair with host input current limit, behind I2C
//
// How it works
// - Reset loads the option pair with 3300h: upper 33h, lower 00h.
// - Upper bit 7 enables battery current monitor buffer; low-power mode forces off.
// - Upper bit 6 enables low-power hot alert on battery; host avoids it with adapter.
// - Bits 5:4 pick power sensing: 00 sum, 01 input, 10 reserved, 11 off.
// - Low-power mode keeps system power sensing and buffer off regardless of field.
// - Upper bit 3 picks input sense resistor: 0 is 10 mOhm, 1 is 5 mOhm.
// - Upper bit 2 picks charge sense resistor: 0 is 10 mOhm, 1 is 5 mOhm.
// - Upper bit 1 picks power gain: 0 is 0.25 uA/W, 1 is 1 uA/W.
// - Upper bit 0 fast compensation works only with 5 mOhm and low adapter resistor.
// - Fast compensation off: limit up to 10 A, higher writes ignored.
// - Fast compensation on: limit clamped at 6.4 A, higher writes ignored.
// - Lower bit 2 pass-through enable clears itself after being set.
// - Ship discharge runs 140 ms then clears; writing zero stops it at once.
`timescale 1ns/100ps
`include "cocr_map.vh"

module cocr_option_reg
#(
  parameter SHIP_CYCLES = `COCR_SHIP_CYCLES
)
(
  // Clock and reset
  input  wire       clock,
  input  wire       reset_n,
  // I2C pins
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe_n,
  // Status pins
  input  wire       low_power_mode_flag,
  input  wire       adpt_res_low,
  // Analog controls
  output reg        batt_current_monitor_en,
  output reg        lowpower_hot_alert_en,
  output reg  [1:0] sys_power_sense_mode,
  output reg        sys_power_sense_on,
  output reg        sys_power_add_batt,
  output reg        input_sense_res_sel,
  output reg        charge_sense_res_sel,
  output reg        sys_power_gain_sel,
  output reg        fast_comp_active,
  output reg  [6:0] host_input_current_limit,
  output reg        pass_through_start,
  output reg        ship_discharge_active
);

  // ---------------------------------------------------------------
  // Constants and helpers
  // ---------------------------------------------------------------
  localparam [15:0] OPT_RESET = `COCR_OPT_RESET;
  localparam [31:0] SHIP_SPAN = SHIP_CYCLES - 1;

  // Highest limit code accepted for the compensation setting
  function [6:0] limit_ceiling;
    input fast;
    begin
      limit_ceiling = fast ? `COCR_LIM_MAX_FAST : `COCR_LIM_MAX_SLOW;
    end
  endfunction

  // Sensing circuit powered in the sum and input-only modes
  function sense_powered;
    input [1:0] mode;
    begin
      sense_powered = (mode == `COCR_SYSTEM_POWER_OUTPUT_SUM) || (mode == `COCR_SYSTEM_POWER_OUTPUT_INPUT);
    end
  endfunction

  wire        wr_en;
  wire [7:0]  wr_addr;
  wire [7:0]  wr_data;
  wire [7:0]  rd_addr;
  reg  [7:0]  rd_data;

  reg  [7:0]  opt_hi_reg;
  reg  [7:0]  opt_lo_reg;
  reg  [6:0]  lim_reg;
  reg  [23:0] ship_cnt_reg;
  reg  [1:0]  lp_sync_reg;
  reg  [1:0]  adpt_sync_reg;

  wire        low_power = lp_sync_reg[1];
  wire [1:0]  system_power_output_mode = opt_hi_reg[`COCR_HI_SYSTEM_POWER_OUTPUT_MSB:`COCR_HI_SYSTEM_POWER_OUTPUT_LSB];
  wire        fast_on   = opt_hi_reg[`COCR_HI_FAST];
  wire [6:0]  lim_max   = limit_ceiling(fast_on);
  wire [23:0] ship_last = SHIP_SPAN[23:0];

  // ---------------------------------------------------------------
  // I2C slave
  // ---------------------------------------------------------------
  cocr_i2c_slave u_i2c
  (
    .clock   (clock),
    .reset_n (reset_n),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe_n(sda_oe_n),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always @*
  begin
    case (rd_addr)
      `COCR_OPT_LO_ADDR: rd_data = opt_lo_reg;
      `COCR_OPT_HI_ADDR: rd_data = opt_hi_reg;
      `COCR_LIM_HI_ADDR: rd_data = {1'b0, lim_reg};
      default:           rd_data = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      opt_hi_reg    <= OPT_RESET[15:8];
      opt_lo_reg    <= OPT_RESET[7:0];
      lim_reg       <= `COCR_LIM_RESET;
      ship_cnt_reg  <= 24'h000000;
      lp_sync_reg   <= 2'h0;
      adpt_sync_reg <= 2'h0;
    end
    else
    begin
      lp_sync_reg   <= {lp_sync_reg[0], low_power_mode_flag};
      adpt_sync_reg <= {adpt_sync_reg[0], adpt_res_low};
      // Self clearing pass-through bit
      if (opt_lo_reg[`COCR_LO_PTM])
      begin
        opt_lo_reg[`COCR_LO_PTM] <= 1'b0;
      end
      // Ship discharge timer
      if (opt_lo_reg[`COCR_LO_SHIP])
      begin
        ship_cnt_reg <= ship_cnt_reg + 24'h000001;
        if (ship_cnt_reg >= ship_last)
        begin
          opt_lo_reg[`COCR_LO_SHIP] <= 1'b0;
        end
      end
      // Host writes take priority over self clearing
      if (wr_en)
      begin
        case (wr_addr)
          `COCR_OPT_LO_ADDR:
          begin
            opt_lo_reg   <= wr_data;
            ship_cnt_reg <= 24'h000000;
          end
          `COCR_OPT_HI_ADDR:
          begin
            opt_hi_reg <= wr_data;
            if (wr_data[`COCR_HI_FAST] && lim_reg > limit_ceiling(1'b1))
            begin
              lim_reg <= limit_ceiling(1'b1);
            end
          end
          `COCR_LIM_HI_ADDR:
          begin
            if (!wr_data[7] && wr_data[6:0] <= lim_max)
            begin
              lim_reg <= wr_data[6:0];
            end
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Registered controls
  // ---------------------------------------------------------------
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      batt_current_monitor_en  <= 1'b0;
      lowpower_hot_alert_en    <= 1'b0;
      sys_power_sense_mode     <= `COCR_SYSTEM_POWER_OUTPUT_OFF;
      sys_power_sense_on       <= 1'b0;
      sys_power_add_batt       <= 1'b0;
      input_sense_res_sel      <= 1'b0;
      charge_sense_res_sel     <= 1'b0;
      sys_power_gain_sel       <= 1'b1;
      fast_comp_active         <= 1'b0;
      host_input_current_limit <= `COCR_LIM_RESET;
      pass_through_start       <= 1'b0;
      ship_discharge_active    <= 1'b0;
    end
    else
    begin
      batt_current_monitor_en  <= opt_hi_reg[`COCR_HI_BATT_MON] & ~low_power;
      lowpower_hot_alert_en    <= opt_hi_reg[`COCR_HI_LP_HOT];
      sys_power_sense_mode     <= system_power_output_mode;
      sys_power_sense_on       <= ~low_power & sense_powered(system_power_output_mode);
      sys_power_add_batt       <= ~low_power & (system_power_output_mode == `COCR_SYSTEM_POWER_OUTPUT_SUM);
      input_sense_res_sel      <= opt_hi_reg[`COCR_HI_IN_RES];
      charge_sense_res_sel     <= opt_hi_reg[`COCR_HI_CHG_RES];
      sys_power_gain_sel       <= opt_hi_reg[`COCR_HI_GAIN];
      fast_comp_active         <= fast_on & opt_hi_reg[`COCR_HI_IN_RES] & adpt_sync_reg[1];
      host_input_current_limit <= (lim_reg > lim_max) ? lim_max : lim_reg;
      pass_through_start       <= opt_lo_reg[`COCR_LO_PTM];
      ship_discharge_active    <= opt_lo_reg[`COCR_LO_SHIP];
    end
  end

endmodule

//--- testbench/cocr_option_reg_checker.sv
// Port checks of the option register block
`timescale 1ns/100ps

module cocr_option_reg_checker
#(
  parameter SHIP_CYCLES = 50
)
(
  // Clock and reset
  input wire logic       clock,
  input wire logic       reset_n,
  // I2C pins
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  // Status pins
  input wire logic       low_power_mode_flag,
  input wire logic       adpt_res_low,
  // Analog controls
  input wire logic       batt_current_monitor_en,
  input wire logic       lowpower_hot_alert_en,
  input wire logic [1:0] sys_power_sense_mode,
  input wire logic       sys_power_sense_on,
  input wire logic       sys_power_add_batt,
  input wire logic       input_sense_res_sel,
  input wire logic       charge_sense_res_sel,
  input wire logic       sys_power_gain_sel,
  input wire logic       fast_comp_active,
  input wire logic [6:0] host_input_current_limit,
  input wire logic       pass_through_start,
  input wire logic       ship_discharge_active
);
  // Discharge length, restarted at every acknowledged byte
  int unsigned ship_cnt;

  always @(posedge clock or negedge reset_n)
    if (!reset_n)
      ship_cnt <= 0;
    else if (!ship_discharge_active || !sda_oe_n)
      ship_cnt <= 0;
    else
      ship_cnt <= ship_cnt + 1;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  AST_RESET_VALUES: assert property ($rose(reset_n) |-> sys_power_sense_mode == 2'h3 &&
    sys_power_gain_sel && !batt_current_monitor_en && host_input_current_limit == 7'h20)
    else $error("Outputs after reset differ from defaults");
  AST_MONITOR_LOWPOWER: assert property (low_power_mode_flag [*5] |-> !batt_current_monitor_en)
    else $error("Current monitor on in low power mode");
  AST_SENSE_LOWPOWER: assert property (low_power_mode_flag [*5] |-> !sys_power_sense_on && !sys_power_add_batt)
    else $error("Power sensing on in low power mode");
  AST_SENSE_MODE: assert property (!low_power_mode_flag [*5] |->
    sys_power_sense_on == !sys_power_sense_mode[1] && sys_power_add_batt == (sys_power_sense_mode == 2'h0))
    else $error("Power sensing does not follow mode");
  AST_FAST_NEEDS_RES: assert property (fast_comp_active |-> input_sense_res_sel)
    else $error("Fast compensation without 5 mOhm input sense");
  AST_LIMIT_SLOW: assert property (host_input_current_limit <= 7'h64)
    else $error("Input current limit above 10 A");
  AST_LIMIT_FAST: assert property (fast_comp_active |-> host_input_current_limit <= 7'h40)
    else $error("Input current limit above 6.4 A with fast compensation");
  AST_PTM_PULSE: assert property (pass_through_start |=> !pass_through_start)
    else $error("Pass-through start longer than one cycle");
  AST_SHIP_LENGTH: assert property (ship_cnt <= SHIP_CYCLES + 2)
    else $error("Ship discharge outlasts its time");

  COV_SHIP: cover property ($rose(ship_discharge_active));
  COV_PTM: cover property (pass_through_start);
  COV_FAST: cover property (fast_comp_active);
endmodule

bind cocr_option_reg cocr_option_reg_checker #(.SHIP_CYCLES(SHIP_CYCLES)) chk_u (.*);

//--- testbench/cocr_host_model.sv
// Behavioural I2C host that reaches the option block
`timescale 1ns/100ps
`include "cocr_map.vh"

module cocr_host_model
(
  // Clock
  clock,
  // I2C lines
  sda_line,
  scl,
  sda_drv
);
  input  wire clock;
  input  wire sda_line;
  output reg  scl = 1'b1;
  output reg  sda_drv = 1'b1;

  task hold(input integer n);
    repeat (n) @(negedge clock);
  endtask

  // SDA only moves while SCL is low, except in start and stop
  task step(input s, input c);
    hold(6);
    sda_drv = s;
    scl = c;
  endtask

  task bitx(input b, output r);
    step(b, 1'b0);
    step(b, 1'b1);
    step(b, 1'b1);
    r = sda_line;
    step(b, 1'b0);
  endtask

  task start;
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
  endtask

  task stop;
    step(1'b0, 1'b0);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
  endtask

  // Ninth bit released so the device can acknowledge
  task xbyte(input [7:0] tx, output [7:0] rx, output nak);
    integer i;
    for (i = 7; i >= 0; i = i - 1)
      bitx(tx[i], rx[i]);
    bitx(1'b1, nak);
  endtask

  task wr(input [6:0] dev, input [7:0] a, input [7:0] d, output nak);
    reg [7:0] r;
    reg       n1;
    reg       n2;
    reg       n3;
    start;
    xbyte({dev, 1'b0}, r, n1);
    xbyte(a, r, n2);
    xbyte(d, r, n3);
    stop;
    nak = n1 | n2 | n3;
  endtask

  task rd(input [7:0] a, output [7:0] d, output nak);
    reg [7:0] r;
    reg       n1;
    reg       n2;
    reg       n3;
    start;
    xbyte({`COCR_I2C_DEV_ADDR, 1'b0}, r, n1);
    xbyte(a, r, n2);
    start;
    xbyte({`COCR_I2C_DEV_ADDR, 1'b1}, r, n3);
    xbyte(8'hFF, d, r[0]);
    stop;
    nak = n1 | n2 | n3;
  endtask
endmodule

//--- testbench/cocr_option_reg_bench.sv
// Self-checking bench of the option register block
`timescale 1ns/100ps
`include "cocr_map.vh"

`define CHK(a, e) \
  begin \
    num_checks = num_checks + 1; \
    if ((a) !== (e)) \
    begin \
      fail_count = fail_count + 1; \
      $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); \
    end \
  end

module cocr_option_reg_bench;
  localparam SHIP = 2000;
  integer    fail_count = 0;
  integer    num_checks = 0;
  integer    ptm_cnt = 0;
  reg        clock;
  reg        reset_n;
  reg        low_power_mode_flag;
  reg        adpt_res_low;
  wire       scl;
  wire       sda_drv;
  wire       sda_line;
  wire       sda_out;
  wire       sda_oe_n;
  wire       batt_current_monitor_en;
  wire       lowpower_hot_alert_en;
  wire [1:0] sys_power_sense_mode;
  wire       sys_power_sense_on;
  wire       sys_power_add_batt;
  wire       input_sense_res_sel;
  wire       charge_sense_res_sel;
  wire       sys_power_gain_sel;
  wire       fast_comp_active;
  wire [6:0] host_input_current_limit;
  wire       pass_through_start;
  wire       ship_discharge_active;

  // Open-drain SDA with pull-up
  assign sda_line = sda_drv & (sda_oe_n | sda_out);

  cocr_option_reg #(.SHIP_CYCLES(SHIP)) dut_u (.*, .scl_in(scl), .sda_in(sda_line));
  cocr_host_model host_u (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

  always @(posedge clock)
    if (pass_through_start === 1'b1)
      ptm_cnt <= ptm_cnt + 1;

  task w(input [7:0] a, input [7:0] d);
    reg n;
    host_u.wr(`COCR_I2C_DEV_ADDR, a, d, n);
    `CHK(n, 1'b0)
  endtask

  task rchk(input [7:0] a, input [7:0] e);
    reg [7:0] d;
    reg       n;
    host_u.rd(a, d, n);
    `CHK({n, d}, {1'b0, e})
  endtask

  task t_reset;
    rchk(`COCR_OPT_LO_ADDR, 8'h00);
    rchk(`COCR_OPT_HI_ADDR, 8'h33);
    `CHK({sys_power_sense_mode, sys_power_gain_sel, fast_comp_active}, 4'hE)
  endtask

  task t_fields;
    integer   m;
    reg [7:0] v;
    reg [8:0] got;
    for (m = 0; m < 4; m = m + 1)
    begin
      v = {m[0], m[1], m[1:0], m[1], m[0], ~m[0], 1'b0};
      w(`COCR_OPT_HI_ADDR, v);
      rchk(`COCR_OPT_HI_ADDR, v);
      got = {batt_current_monitor_en, lowpower_hot_alert_en, sys_power_sense_mode, sys_power_sense_on,
             sys_power_add_batt, input_sense_res_sel, charge_sense_res_sel, sys_power_gain_sel};
      `CHK(got, {v[7:4], ~v[5], v[5:4] == 2'h0, v[3:1]})
    end
  endtask

  task t_lowpower;
    low_power_mode_flag = 1'b1;
    w(`COCR_OPT_HI_ADDR, 8'h80);
    `CHK({batt_current_monitor_en, sys_power_sense_on, sys_power_add_batt}, 3'h0)
    low_power_mode_flag = 1'b0;
    host_u.hold(6);
    `CHK({batt_current_monitor_en, sys_power_sense_on, sys_power_add_batt}, 3'h7)
  endtask

  task t_limit;
    w(`COCR_OPT_HI_ADDR, 8'h08);
    w(`COCR_LIM_HI_ADDR, {1'b0, `COCR_LIM_MAX_SLOW});
    w(`COCR_LIM_HI_ADDR, 8'h65);
    rchk(`COCR_LIM_HI_ADDR, {1'b0, `COCR_LIM_MAX_SLOW});
    adpt_res_low = 1'b1;
    w(`COCR_OPT_HI_ADDR, 8'h01);
    `CHK(fast_comp_active, 1'b0)
    w(`COCR_OPT_HI_ADDR, 8'h09);
    `CHK({fast_comp_active, host_input_current_limit}, {1'b1, `COCR_LIM_MAX_FAST})
    w(`COCR_LIM_HI_ADDR, 8'h41);
    `CHK(host_input_current_limit, `COCR_LIM_MAX_FAST)
    adpt_res_low = 1'b0;
    host_u.hold(6);
    `CHK(fast_comp_active, 1'b0)
  endtask

  task t_ptm;
    integer n0;
    n0 = ptm_cnt;
    w(`COCR_OPT_LO_ADDR, 8'h04);
    `CHK(ptm_cnt - n0, 1)
    rchk(`COCR_OPT_LO_ADDR, 8'h00);
  endtask

  task t_ship;
    w(`COCR_OPT_LO_ADDR, 8'h02);
    `CHK(ship_discharge_active, 1'b1)
    w(`COCR_OPT_LO_ADDR, 8'h00);
    `CHK(ship_discharge_active, 1'b0)
    w(`COCR_OPT_LO_ADDR, 8'h02);
    host_u.hold(SHIP);
    `CHK(ship_discharge_active, 1'b0)
    rchk(`COCR_OPT_LO_ADDR, 8'h00);
  endtask

  task t_unmapped;
    reg n;
    w(8'h50, 8'hAA);
    rchk(8'h50, 8'h00);
    host_u.wr(`COCR_I2C_DEV_ADDR ^ 7'h01, `COCR_OPT_HI_ADDR, 8'h00, n);
    `CHK(n, 1'b1)
    rchk(`COCR_OPT_HI_ADDR, 8'h09);
  endtask

  task close_out;
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial
  begin
    reset_n = 1'b0;
    low_power_mode_flag = 1'b0;
    adpt_res_low = 1'b0;
    repeat (8) @(negedge clock);
    reset_n = 1'b1;
    host_u.hold(4);
    t_reset;
    t_fields;
    t_lowpower;
    t_limit;
    t_ptm;
    t_ship;
    t_unmapped;
    close_out;
  end

  // Tests need about 25000 cycles
  initial
  begin
    repeat (60000) @(posedge clock);
    fail_count = fail_count + 1;
    close_out;
  end
endmodule
